// File: bench/i2cadc_master.sv
// Purpose: Behavioural bus master that drives the serial converter slave.
// Assumes: Lines are resolved in the bench; one bit takes eight system clocks.
// Notes: The master waits, bounded, while the slave holds the clock low.
`timescale 1ns/10ps
`default_nettype none
module i2cadc_master (
    // Clock and resolved bus lines.
    input wire logic clk_sys,
    input wire logic scl_line,
    input wire logic sda_line,
    // Open-drain drive levels; a one leaves the line released.
    output logic m_scl,
    output logic m_sda
);
    int stretch; // Clocks the last pulse was held low by the slave.
    int hold; // Hold seen on the first bit of the last byte read.
    initial begin
        m_scl = 1'b1; // Both lines idle high.
        m_sda = 1'b1;
    end
    task w(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : w
    // One pulse; data moves only while the clock is low.
    task bit_io(input logic b, output logic r);
        m_sda = b;
        w(3);
        m_scl = 1'b1;
        w(1);
        stretch = 0;
        while (scl_line !== 1'b1 && stretch < 2000) begin
            w(1);
            stretch++;
        end
        w(2);
        r = sda_line;
        m_scl = 1'b0;
        w(2);
    endtask : bit_io
    // Falling data while the clock is high; also a repeated start.
    task start();
        m_sda = 1'b1;
        w(2);
        m_scl = 1'b1;
        w(3);
        m_sda = 1'b0;
        w(3);
        m_scl = 1'b0;
        w(2);
    endtask : start
    // Rising data while the clock is high.
    task stop();
        m_sda = 1'b0;
        w(2);
        m_scl = 1'b1;
        w(3);
        m_sda = 1'b1;
        w(4);
    endtask : stop
    task wr_byte(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack_n);
    endtask : wr_byte
    // The master answers each byte with low or released data.
    task rd_byte(input logic ack_n, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            if (i == 0) hold = stretch;
            d = {d[6:0], r};
        end
        bit_io(ack_n, r);
    endtask : rd_byte
endmodule : i2cadc_master
`default_nettype wire

// File: bench/test_i2cadc_slave.sv
// Purpose: Self-checking bench for the serial converter slave.
// Assumes: An ideal comparator that compares a bench value with the trial code.
// Notes: Expected bytes are the bench value split high and low.
`timescale 1ns/10ps
`default_nettype none
module test_i2cadc_slave;
    import i2cadc_pkg::*;
    logic clk_sys, reset_n, scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda, ack, ext_ref;
    logic track_hold, adc_power, ref_enable, hs_mode;
    logic [3:0] pins;
    logic [7:0] d;
    logic [WORD_BITS-1:0] dac_code, analog;
    int num_errors, checks;
    // Open-drain lines: low when any party pulls.
    wire logic scl_line = m_scl & (scl_oe_n | scl_o);
    wire logic sda_line = m_sda & (sda_oe_n | sda_o);
    wire logic comp = (analog >= dac_code);
    i2cadc_master i_i2cadc_master (.clk_sys(clk_sys), .scl_line(scl_line),
        .sda_line(sda_line), .m_scl(m_scl), .m_sda(m_sda));
    i2cadc_slave i_i2cadc_slave (.clk_sys(clk_sys), .reset_n(reset_n), .scl_i(scl_line),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .address_select_pins(pins), .reference_adjust_pin(ext_ref),
        .comp_above_i(comp), .track_hold(track_hold), .dac_code(dac_code),
        .adc_power(adc_power), .ref_enable(ref_enable), .hs_mode(hs_mode));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task give_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    // Two conversions back to back, then a refused third ending the read.
    task t_read();
        analog = 16'h9C35;
        i_i2cadc_master.start();
        i_i2cadc_master.wr_byte({ADDR_FIXED, pins, 1'b0}, ack);
        check("ack", 16'(ack), 16'h0000);
        check("track", 16'(track_hold), 16'h0001);
        i_i2cadc_master.w(6);
        check("sampled", 16'(track_hold), 16'h0000);
        check("ref", 16'(ref_enable), 16'h0001);
        check("power", 16'(adc_power), 16'h0001);
        i_i2cadc_master.rd_byte(1'b0, d);
        check("hold", 16'(i_i2cadc_master.hold > 300), 16'h0001);
        check("msb", 16'(d), 16'h009C);
        analog = 16'h1234;
        i_i2cadc_master.rd_byte(1'b0, d);
        check("lsb", 16'(d), 16'h0035);
        i_i2cadc_master.rd_byte(1'b0, d);
        check("hold2", 16'(i_i2cadc_master.hold > 300), 16'h0001);
        check("msb2", 16'(d), 16'h0012);
        i_i2cadc_master.rd_byte(1'b1, d);
        check("lsb2", 16'(d), 16'h0034);
        i_i2cadc_master.w(6);
        check("ref off", 16'(ref_enable), 16'h0000);
        check("power off", 16'(adc_power), 16'h0000);
        i_i2cadc_master.stop();
    endtask : t_read
    // A foreign address is refused; the master then retries with the own one.
    task t_foreign();
        pins = 4'h5;
        i_i2cadc_master.start();
        i_i2cadc_master.wr_byte({ADDR_FIXED, ~pins, 1'b1}, ack);
        i_i2cadc_master.w(30);
        check("nack", 16'(ack), 16'h0001);
        check("idle", 16'({adc_power, sda_oe_n, scl_oe_n}), 16'h0003);
        i_i2cadc_master.stop();
        i_i2cadc_master.start();
        i_i2cadc_master.wr_byte({ADDR_FIXED, pins, 1'b1}, ack);
        check("retry ack", 16'(ack), 16'h0000);
        i_i2cadc_master.rd_byte(1'b1, d);
        check("retry msb", 16'(d), 16'h0012);
        i_i2cadc_master.w(6);
        check("ref kept", 16'({ref_enable, sda_oe_n, scl_oe_n}), 16'h0007);
        i_i2cadc_master.stop();
    endtask : t_foreign
    // High-speed entry, repeated start, external reference, then stop.
    task t_hs();
        i_i2cadc_master.start();
        i_i2cadc_master.wr_byte(8'h0D, ack);
        i_i2cadc_master.w(6);
        check("hs nack", 16'(ack), 16'h0001);
        check("hs on", 16'(hs_mode), 16'h0001);
        i_i2cadc_master.start();
        i_i2cadc_master.wr_byte({ADDR_FIXED, pins, 1'b0}, ack);
        i_i2cadc_master.w(6);
        check("hs ack", 16'(ack), 16'h0000);
        check("ext ref", 16'(ref_enable), 16'h0000);
        check("hs kept", 16'(hs_mode), 16'h0001);
        i_i2cadc_master.rd_byte(1'b0, d);
        check("hs msb", 16'(d), 16'h0012);
        i_i2cadc_master.rd_byte(1'b1, d);
        check("hs lsb", 16'(d), 16'h0034);
        i_i2cadc_master.stop();
        i_i2cadc_master.w(6);
        check("hs off", 16'(hs_mode), 16'h0000);
    endtask : t_hs
    initial begin
        reset_n = 1'b0;
        pins = 4'hA;
        ext_ref = 1'b0;
        analog = 16'h0000;
        repeat (10) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        check("reset", 16'({hs_mode, adc_power, ref_enable, scl_oe_n, sda_oe_n}),
            16'h0003);
        i_i2cadc_master.w(3);
        t_read();
        t_foreign();
        ext_ref = 1'b1;
        t_hs();
        give_verdict();
    end
    // Cut a hang short well past the expected run time.
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        give_verdict();
    end
endmodule : test_i2cadc_slave
`default_nettype wire

// File: design/i2cadc_pkg.sv
// Purpose: Shared constants and types for the serial ADC slave interface.
// Assumes: System clock of 100 MHz and a 4 MHz conversion tick.
// Notes: Shared widths, codes and counts live here; pin, synchroniser and counter widths are declared in the slave.
`default_nettype none
package i2cadc_pkg;
    // Fixed upper bits of the 7-bit slave address.
    localparam logic [2:0] ADDR_FIXED = 3'h3;
    // Upper five bits of the high-speed master code, low three are ignored.
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    // Number of data bits in one byte.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Index of the last data bit in a byte, counted from zero.
    localparam logic [3:0] LAST_BIT = 4'h7;
    // Result width and trailing sub-bit count.
    localparam int RESULT_BITS = 14;
    localparam int SUB_BITS = 2;
    localparam int WORD_BITS = RESULT_BITS + SUB_BITS;
    // Depth of the result buffer.
    localparam int FIFO_DEPTH = 4;
    // Clock rates in Hz and the divider that makes the conversion tick.
    localparam int SYS_CLK_HZ = 100000000;
    localparam int OSC_HZ = 4000000;
    localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ;
    localparam logic [4:0] OSC_LAST = 5'(OSC_DIV - 1);
    localparam logic [4:0] OSC_ZERO = 5'h00;
    // First trial bit and last trial bit of the approximation.
    localparam logic [WORD_BITS-1:0] SAR_FIRST = 16'h8000;
    localparam logic [WORD_BITS-1:0] SAR_LAST = 16'h0001;
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;

    // Protocol states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_ACK = 6'h04,
        ST_CONV = 6'h08,
        ST_SEND = 6'h10,
        ST_MACK = 6'h20
    } i2cadc_state_e;

    // One finished conversion: result followed by the two sub-bits.
    typedef struct packed {
        logic [RESULT_BITS-1:0] data;
        logic [SUB_BITS-1:0] sub;
    } i2cadc_result_s;

    // Synchronised view of the two bus lines.
    typedef struct packed {
        logic scl;
        logic sda;
    } i2cadc_bus_s;
endpackage : i2cadc_pkg
`default_nettype wire

// File: design/i2cadc_slave.sv
// Purpose: Two-wire slave front end and conversion control of a serial ADC.
// Assumes: Bus lines, strap pins and comparator are asynchronous inputs.
// Notes: The analog comparator and trial code are ports; the SAR logic is here.
`timescale 1ns/10ps
`default_nettype none

// Small synchronous FIFO holding finished conversion words.
module i2cadc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Storage words.
    logic [WIDTH-1:0] mem [DEPTH];
    // Pointers carry one extra bit so full and empty differ.
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    // Pointer comparisons decide full and empty honestly.
    wire ptr_same = wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0];
    wire is_full = ptr_same && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
    wire is_empty = wr_ptr_ff == rd_ptr_ff;
    wire do_push = in_valid && !is_full;
    wire do_pop = out_ready && !is_empty;

    assign in_ready = !is_full;
    assign out_valid = !is_empty;
    assign out_data = mem[rd_ptr_ff[AW-1:0]];

    // The array has no reset; only the pointers need a defined value.
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    // Pointers move on accepted pushes and pops.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + (do_push ? 1'b1 : 1'b0);
            rd_ptr_ff <= rd_ptr_ff + (do_pop ? 1'b1 : 1'b0);
        end
    end
endmodule : i2cadc_fifo

// Top of the slave: bus engine, conversion engine and power control.
module i2cadc_slave
    import i2cadc_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Serial clock line; enable is low while the line is held low.
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    // Serial data line; enable is low while the line is driven.
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Strap and analog-side inputs.
    input wire logic [3:0] address_select_pins,
    input wire logic reference_adjust_pin,
    input wire logic comp_above_i,
    // Analog-side controls and status.
    output logic track_hold,
    output logic [WORD_BITS-1:0] dac_code,
    output logic adc_power,
    output logic ref_enable,
    output logic hs_mode
);
    // Two-stage synchronisers; stage one is read only by stage two.
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic [1:0] comp_sync_ff;
    logic [1:0] ext_sync_ff;
    logic [3:0] strap_meta_ff;
    logic [3:0] strap_ff;
    // Previous synchronised bus levels for edge finding.
    i2cadc_bus_s bus_prev_ff;
    i2cadc_bus_s bus_now;

    // Protocol engine state.
    i2cadc_state_e state_ff;
    i2cadc_state_e nxt_state;
    logic [3:0] bitcnt_ff;
    logic [7:0] shift_in_ff;
    logic [WORD_BITS-1:0] shift_out_ff;
    logic byte1_ff;
    logic matched_ff;
    logic rw_ff;
    logic master_ack_ff;
    // Registered outputs.
    logic sda_oe_n_ff;
    logic scl_oe_n_ff;
    logic track_ff;
    logic hs_mode_ff;
    logic ref_enable_ff;
    logic adc_power_ff;
    // Conversion engine.
    logic [4:0] osc_cnt_ff;
    logic sar_busy_ff;
    logic sar_done_ff;
    logic [WORD_BITS-1:0] sar_mask_ff;
    logic [WORD_BITS-1:0] dac_code_ff;
    // FIFO handshake.
    logic fifo_in_ready;
    logic fifo_out_valid;
    i2cadc_result_s fifo_out_data;

    assign bus_now = '{scl: scl_sync_ff[1], sda: sda_sync_ff[1]};

    // Bus conditions, all taken from synchronised levels.
    wire scl_rise = bus_now.scl && !bus_prev_ff.scl;
    wire scl_fall = !bus_now.scl && bus_prev_ff.scl;
    wire scl_high = bus_now.scl && bus_prev_ff.scl;
    wire start_det = scl_high && bus_prev_ff.sda && !bus_now.sda;
    wire stop_det = scl_high && !bus_prev_ff.sda && bus_now.sda;
    wire ext_ref = ext_sync_ff[1];
    wire comp_above = comp_sync_ff[1];

    // Address decode on the completed byte.
    wire addr_hit = (shift_in_ff[7:5] == ADDR_FIXED) && (shift_in_ff[4:1] == strap_ff);
    wire hs_hit = shift_in_ff[7:3] == HS_CODE_TOP;
    wire byte_done = (state_ff == ST_ADDR) && scl_fall && (bitcnt_ff == BYTE_BITS);
    wire state_change = nxt_state != state_ff;
    wire conv_start = (nxt_state == ST_CONV) && state_change;
    wire ack_slot_end = (state_ff == ST_ACK) && scl_fall;
    wire mack_end = (state_ff == ST_MACK) && scl_fall;
    wire load_word = (state_ff == ST_CONV) && fifo_out_valid;
    wire osc_tick = osc_cnt_ff == OSC_LAST;
    wire sar_push = sar_done_ff && fifo_in_ready;
    // Trial code for the next step: keep or drop this bit, try the next.
    wire [WORD_BITS-1:0] sar_keep = comp_above ? dac_code_ff : (dac_code_ff & ~sar_mask_ff);
    wire [WORD_BITS-1:0] nxt_dac = sar_keep | (sar_mask_ff >> 1);

    // Pin drive wishes, registered below so outputs come from flops.
    wire drive_ack = (state_ff == ST_ACK) && matched_ff;
    wire drive_zero = (state_ff == ST_SEND) && !shift_out_ff[WORD_BITS-1];
    wire hold_scl = state_ff == ST_CONV;
    // Acquisition window: last two clocks of a byte that leads into conversion.
    wire track_addr = ((state_ff == ST_ADDR) && (bitcnt_ff >= LAST_BIT)) || drive_ack;
    wire track_read = byte1_ff && (((state_ff == ST_SEND) && (bitcnt_ff == LAST_BIT))
        || (state_ff == ST_MACK));

    // Synchronisers for the bus lines, the comparator and the reference pin.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            comp_sync_ff <= 2'h0;
            ext_sync_ff <= 2'h0;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            comp_sync_ff <= {comp_sync_ff[0], comp_above_i};
            ext_sync_ff <= {ext_sync_ff[0], reference_adjust_pin};
        end
    end

    // Strap pins are levels; two flops settle them before the decode.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            strap_meta_ff <= 4'h0;
            strap_ff <= 4'h0;
        end else begin
            strap_meta_ff <= address_select_pins;
            strap_ff <= strap_meta_ff;
        end
    end

    // Protocol next state; STOP and START override anything in progress.
    always_comb begin
        nxt_state = state_ff;
        if (stop_det) begin
            nxt_state = ST_IDLE;
        end else if (start_det) begin
            nxt_state = ST_ADDR;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_state = ST_IDLE;
                end
                ST_ADDR: begin
                    // A foreign byte drops back to idle without touching the bus.
                    if (byte_done) begin
                        nxt_state = (addr_hit || hs_hit) ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    // The high-speed code ends here; a match goes on to convert.
                    if (scl_fall) begin
                        nxt_state = matched_ff ? ST_CONV : ST_IDLE;
                    end
                end
                ST_CONV: begin
                    if (fifo_out_valid) begin
                        nxt_state = ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (scl_fall && (bitcnt_ff == LAST_BIT)) begin
                        nxt_state = ST_MACK;
                    end
                end
                ST_MACK: begin
                    // Acknowledge after the second byte starts the next sample.
                    if (scl_fall) begin
                        nxt_state = !master_ack_ff ? ST_IDLE : (byte1_ff ? ST_CONV : ST_SEND);
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    // State register and bit counter.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            bitcnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            if (state_change || start_det) begin
                bitcnt_ff <= 4'h0;
            end else if (((state_ff == ST_ADDR) && scl_rise) || ((state_ff == ST_SEND) && scl_fall)) begin
                bitcnt_ff <= bitcnt_ff + 4'h1;
            end
        end
    end

    // Address byte capture on rising edges; decision flags at byte end.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shift_in_ff <= 8'h00;
            matched_ff <= 1'b0;
            rw_ff <= 1'b1;
        end else begin
            if ((state_ff == ST_ADDR) && scl_rise) begin
                shift_in_ff <= {shift_in_ff[6:0], bus_now.sda};
            end
            if (byte_done) begin
                matched_ff <= addr_hit;
            end
            if (byte_done && addr_hit) begin
                rw_ff <= shift_in_ff[0];
            end
        end
    end

    // Result shifter: loaded from the FIFO, shifted on falling edges.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shift_out_ff <= WORD_ZERO;
            byte1_ff <= 1'b0;
            master_ack_ff <= 1'b0;
        end else begin
            if (load_word) begin
                shift_out_ff <= fifo_out_data;
                byte1_ff <= 1'b0;
            end else if ((state_ff == ST_SEND) && scl_fall) begin
                shift_out_ff <= {shift_out_ff[WORD_BITS-2:0], 1'b0};
            end else if (mack_end && master_ack_ff) begin
                byte1_ff <= !byte1_ff;
            end
            if ((state_ff == ST_MACK) && scl_rise) begin
                master_ack_ff <= !bus_now.sda;
            end
        end
    end

    // Registered pin drive; a released line has its enable high.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sda_oe_n_ff <= 1'b1;
            scl_oe_n_ff <= 1'b1;
            track_ff <= 1'b0;
        end else begin
            sda_oe_n_ff <= !(drive_ack || drive_zero);
            scl_oe_n_ff <= !hold_scl;
            track_ff <= track_addr || track_read;
        end
    end

    // Timing mode: fast/standard after reset and after any STOP.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hs_mode_ff <= 1'b0;
        end else if (stop_det) begin
            hs_mode_ff <= 1'b0;
        end else if (ack_slot_end && !matched_ff) begin
            hs_mode_ff <= 1'b1;
        end
    end

    // Reference power; external reference mode keeps it off while the pin stays high.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ref_enable_ff <= 1'b0;
        end else if (ext_ref) begin
            ref_enable_ff <= 1'b0;
        end else if (ack_slot_end && matched_ff) begin
            ref_enable_ff <= 1'b1;
        end else if (mack_end && !master_ack_ff && !rw_ff) begin
            ref_enable_ff <= 1'b0;
        end
    end

    // Converter power follows a conversion from start to result push.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            adc_power_ff <= 1'b0;
        end else if (conv_start) begin
            adc_power_ff <= 1'b1;
        end else if (sar_push) begin
            adc_power_ff <= 1'b0;
        end
    end

    // Free-running divider that stands in for the internal oscillator.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            osc_cnt_ff <= OSC_ZERO;
        end else begin
            osc_cnt_ff <= osc_tick ? OSC_ZERO : osc_cnt_ff + 5'h01;
        end
    end

    // Successive approximation, one bit per oscillator tick.
    // A full FIFO holds the finished word here, and converter power stays on until it is pushed.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sar_busy_ff <= 1'b0;
            sar_done_ff <= 1'b0;
            sar_mask_ff <= WORD_ZERO;
            dac_code_ff <= WORD_ZERO;
        end else if (conv_start) begin
            sar_busy_ff <= 1'b1;
            sar_done_ff <= 1'b0;
            sar_mask_ff <= SAR_FIRST;
            dac_code_ff <= SAR_FIRST;
        end else if (sar_busy_ff && osc_tick) begin
            dac_code_ff <= nxt_dac;
            sar_mask_ff <= sar_mask_ff >> 1;
            sar_busy_ff <= sar_mask_ff != SAR_LAST;
            sar_done_ff <= sar_mask_ff == SAR_LAST;
        end else if (sar_push) begin
            sar_done_ff <= 1'b0;
        end
    end

    // Result buffer between the converter and the bus shifter.
    i2cadc_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(sar_done_ff),
        .in_ready(fifo_in_ready),
        .in_data(dac_code_ff),
        .out_valid(fifo_out_valid),
        .out_ready(state_ff == ST_CONV),
        .out_data(fifo_out_data)
    );

    // Edge history of the bus lines.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_prev_ff <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            bus_prev_ff <= bus_now;
        end
    end

    // Output mapping; the data and clock drive levels are always low.
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_oe_n = sda_oe_n_ff;
    assign scl_oe_n = scl_oe_n_ff;
    assign track_hold = track_ff;
    assign dac_code = dac_code_ff;
    assign adc_power = adc_power_ff;
    assign ref_enable = ref_enable_ff;
    assign hs_mode = hs_mode_ff;

    // Checks on the behaviour above.
    a_idle_passive: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == ST_IDLE) && $past(state_ff == ST_IDLE) |-> sda_oe_n_ff && scl_oe_n_ff)
        else $error("Device drives the bus while idle.");
    a_addr_ack_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == ST_ACK) && matched_ff |=> !sda_oe_n_ff)
        else $error("Matching address not acknowledged.");
    a_hs_code_nack: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == ST_ACK) && !matched_ff && scl_fall |=> sda_oe_n_ff && hs_mode_ff)
        else $error("High-speed code not handled with not-acknowledge.");
    a_conv_stretch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == ST_CONV) ##1 (state_ff == ST_CONV) |-> !scl_oe_n_ff)
        else $error("Clock released during conversion.");
    a_stop_fs_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
        stop_det |=> !hs_mode_ff && (state_ff == ST_IDLE))
        else $error("STOP did not restore fast/standard mode.");
    a_addr_starts_conv: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == ST_ACK) && matched_ff && scl_fall |=> sar_busy_ff && adc_power_ff)
        else $error("Good address did not start a conversion.");
    a_osc_spacing: assert property (@(posedge clk_sys) disable iff (!reset_n)
        osc_tick |=> !osc_tick [*8])
        else $error("Conversion tick spacing too short.");
    a_track_before: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == ST_ACK) && matched_ff ##1 (state_ff == ST_ACK) |-> track_ff)
        else $error("No tracking before conversion.");
    a_ref_nack_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mack_end && !master_ack_ff && !rw_ff |=> !ref_enable_ff)
        else $error("Reference not shut down on not-acknowledge.");
    a_nack_ends: assert property (@(posedge clk_sys) disable iff (!reset_n)
        mack_end && !master_ack_ff && !stop_det && !start_det |=> state_ff == ST_IDLE ##1 sda_oe_n_ff)
        else $error("Not-acknowledge did not end the transfer.");
    a_foreign_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
        byte_done && !addr_hit && !hs_hit |=> (state_ff == ST_IDLE) && !sar_busy_ff ##1 sda_oe_n_ff)
        else $error("Foreign address was answered.");
endmodule : i2cadc_slave
`default_nettype wire
